/* common/vpop_pkg.sv */
`default_nettype none
package vpop_pkg;
  localparam int ELEM_W = 64;
  localparam int RES_W = 7;
  localparam int PART_W = 4;
  localparam int PARTS = ELEM_W / PART_W;
  localparam int VL_W = 8;
  localparam int MAX_VL = 128;
  localparam logic [1:0] K_POP = 2'h1;
  localparam logic [1:0] K_PARITY = 2'h2;
  localparam logic [1:0] K_LZC = 2'h3;
  localparam logic [6:0] ALL_ZERO_COUNT = 7'h40;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_POPULATION_COUNT,
    OP_PARITY,
    OP_LEADING_ZERO_COUNT
  } op_t;
endpackage : vpop_pkg
`default_nettype wire

/* logic/vector_popcount_parity_lzc.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: k field code 1 population count, 2 parity, 3 leading-zero count.
// RULE2: Reserving this unit also reserves divide/sqrt, and the reverse.
// RULE3: Issue holds scalar divide/sqrt until shared vector work completes.
// RULE4: Count set bits per source element, write same destination index, for VL.
// RULE5: Only result bits 0 to 6 delivered; higher element bits forced zero.
// RULE6: Population count ranges 0 to 64 decimal.
// RULE7: Parity reuses population count, outputs only its bit 0.
// RULE8: Parity 0 for even set-bit count, 1 for odd.
// RULE9: Leading zeros above highest set bit; 0 if bit 63 set, 64 if none.
// RULE10: Two identical slices: even elements pipe 0, odd elements pipe 1.
// RULE11: Operands arrive on divide/sqrt wires, 4 bits from each steering source.
// RULE12: Results return only on the two low-order steering slices, 7 bits.
// RULE13: Mark each result valid per pipe; release reservation after last element.
module vector_popcount_parity_lzc #(
  parameter int VL_W = vpop_pkg::VL_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [1:0] kField,
  input wire logic [VL_W-1:0] elementCount,
  input wire logic divSqrtBusy,
  input wire logic [vpop_pkg::ELEM_W-1:0] operandEven,
  input wire logic operandEvenValid,
  input wire logic [vpop_pkg::ELEM_W-1:0] operandOdd,
  input wire logic operandOddValid,
  output logic [vpop_pkg::RES_W-1:0] resultEven,
  output logic resultEvenValid,
  output logic [vpop_pkg::RES_W-1:0] resultOdd,
  output logic resultOddValid,
  output logic unitReserved,
  output logic scalarDivHold,
  output logic done
);
  typedef enum logic {IDLE, RUN} state_t;

  state_t state, next_state;
  vpop_pkg::op_t op, next_op;
  logic [VL_W-1:0] remaining, next_remaining;
  logic [vpop_pkg::RES_W-1:0] next_resultEven, next_resultOdd;
  logic next_resultEvenValid, next_resultOddValid;
  logic next_unitReserved, next_done;
  logic [vpop_pkg::RES_W-1:0] sliceRes [2];
  logic [1:0] sliceIn;

  assign sliceIn = {operandOddValid, operandEvenValid};

  // Two identical slices; operand arrives as 4-bit steering parts
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_slice // RULE10
      logic [vpop_pkg::ELEM_W-1:0] opnd;
      logic [6:0] pop;
      logic [6:0] lzc;
      always_comb begin
        opnd = (s == 0) ? operandEven : operandOdd; // RULE11
        pop = 7'h00;
        for (int p = 0; p < vpop_pkg::PARTS; p++) begin
          for (int b = 0; b < vpop_pkg::PART_W; b++) begin
            pop = pop + {6'h00, opnd[p*vpop_pkg::PART_W + b]}; // RULE4 RULE6
          end
        end
        lzc = vpop_pkg::ALL_ZERO_COUNT; // RULE9
        for (int b = 0; b < vpop_pkg::ELEM_W; b++) begin
          if (opnd[b]) begin
            lzc = 7'(vpop_pkg::ELEM_W - 1 - b); // RULE9
          end
        end
        unique case (op)
          vpop_pkg::OP_POPULATION_COUNT: sliceRes[s] = pop;
          vpop_pkg::OP_PARITY: sliceRes[s] = {6'h00, pop[0]}; // RULE7 RULE8
          vpop_pkg::OP_LEADING_ZERO_COUNT: sliceRes[s] = lzc;
          vpop_pkg::OP_NONE: sliceRes[s] = 7'h00;
        endcase
      end
    end
  endgenerate

  always_comb begin
    logic [VL_W-1:0] taken;
    taken = '0;
    next_state = state;
    next_op = op;
    next_remaining = remaining;
    next_resultEven = resultEven;
    next_resultOdd = resultOdd;
    next_resultEvenValid = 1'b0;
    next_resultOddValid = 1'b0;
    next_unitReserved = unitReserved;
    next_done = 1'b0;
    unique case (state)
      IDLE: begin
        // Shared unit busy with divide/sqrt: refuse to start
        if (go && !divSqrtBusy && elementCount != '0) begin // RULE2
          next_state = RUN;
          next_remaining = elementCount;
          next_unitReserved = 1'b1; // RULE2
          unique case (kField) // RULE1
            vpop_pkg::K_POP: next_op = vpop_pkg::OP_POPULATION_COUNT;
            vpop_pkg::K_PARITY: next_op = vpop_pkg::OP_PARITY;
            vpop_pkg::K_LZC: next_op = vpop_pkg::OP_LEADING_ZERO_COUNT;
            default: begin
              next_op = vpop_pkg::OP_NONE;
              next_state = IDLE;
              next_unitReserved = 1'b0;
            end
          endcase
        end
      end
      RUN: begin
        // Even pipe owns the earlier element when only one remains
        if (sliceIn[0] && remaining != '0) begin
          next_resultEven = sliceRes[0]; // RULE12 RULE5
          next_resultEvenValid = 1'b1; // RULE13
          taken = taken + 1'b1;
        end
        if (sliceIn[1] && remaining > taken) begin
          next_resultOdd = sliceRes[1]; // RULE12 RULE5
          next_resultOddValid = 1'b1; // RULE13
          taken = taken + 1'b1;
        end
        next_remaining = remaining - taken;
        if (next_remaining == '0) begin
          next_state = IDLE; // RULE13
          next_unitReserved = 1'b0;
          next_done = 1'b1;
          next_op = vpop_pkg::OP_NONE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= IDLE;
      op <= vpop_pkg::OP_NONE;
      remaining <= '0;
      resultEven <= 7'h00;
      resultOdd <= 7'h00;
      resultEvenValid <= 1'b0;
      resultOddValid <= 1'b0;
      unitReserved <= 1'b0;
      scalarDivHold <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      remaining <= next_remaining;
      resultEven <= next_resultEven;
      resultOdd <= next_resultOdd;
      resultEvenValid <= next_resultEvenValid;
      resultOddValid <= next_resultOddValid;
      unitReserved <= next_unitReserved;
      scalarDivHold <= next_unitReserved; // RULE3
      done <= next_done;
    end
  end
endmodule : vector_popcount_parity_lzc
`default_nettype wire

/* dv/vpop_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module vpop_monitor #(
  parameter int VL_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic divSqrtBusy,
  input wire logic done,
  input wire logic [1:0] kField,
  input wire logic [VL_W-1:0] elementCount,
  input wire logic operandEvenValid,
  input wire logic operandOddValid,
  input wire logic resultEvenValid,
  input wire logic resultOddValid,
  input wire logic unitReserved,
  input wire logic scalarDivHold,
  input wire logic [6:0] resultEven
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_reserve_start: assert property (go && !unitReserved && !divSqrtBusy
    && kField != 2'h0 && elementCount != '0 |=> unitReserved)
    else $error("no reserve");
  a_busy_refused: assert property (!unitReserved && divSqrtBusy
    |=> !unitReserved) else $error("busy taken");
  a_hold_mirror: assert property (scalarDivHold == unitReserved)
    else $error("hold");
  a_even_answer: assert property (unitReserved && operandEvenValid
    |=> resultEvenValid) else $error("even lost");
  a_odd_cause: assert property (resultOddValid |-> $past(operandOddValid))
    else $error("odd stray");
  a_done_release: assert property (done |-> !unitReserved)
    else $error("kept");
  a_done_result: assert property (done |-> resultEvenValid || resultOddValid)
    else $error("empty done");
  a_count_range: assert property (resultEvenValid |-> resultEven <= 7'h40)
    else $error("range");
endmodule : vpop_monitor
bind vector_popcount_parity_lzc vpop_monitor #(.VL_W(VL_W)) mon (
  .core_clk(core_clk),
  .reset(reset),
  .go(go),
  .divSqrtBusy(divSqrtBusy),
  .done(done),
  .kField(kField),
  .elementCount(elementCount),
  .operandEvenValid(operandEvenValid),
  .operandOddValid(operandOddValid),
  .resultEvenValid(resultEvenValid),
  .resultOddValid(resultOddValid),
  .unitReserved(unitReserved),
  .scalarDivHold(scalarDivHold),
  .resultEven(resultEven)
);
`default_nettype wire

/* dv/steer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module steer_model (
  input wire logic core_clk,
  input wire logic unitReserved,
  input wire logic slow,
  output logic [63:0] opEven,
  output logic evenValid,
  output logic [63:0] opOdd,
  output logic oddValid
);
  logic [63:0] vec [4];
  logic skip = 0;
  int idx = 0;
  initial {opEven, opOdd, evenValid, oddValid} = '0;
  always @(posedge core_clk) begin
    // Stall pattern taken at the edge, before the bench moves slow
    skip = slow && !skip;
    #1;
    if (!unitReserved) idx = 0;
    if (unitReserved && idx < 4 && !skip) begin
      {opEven, opOdd, evenValid, oddValid} = {vec[idx], vec[idx+1], 2'h3};
      idx += 2;
    end else begin
      // Idle data flips so stale words never look fresh
      {opEven, opOdd, evenValid, oddValid} = {~opEven, ~opOdd, 2'h0};
    end
  end
endmodule : steer_model
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 0, reset = 1, go = 0, divSqrtBusy = 0, slow = 0;
  logic [1:0] kField = 0;
  logic [7:0] elementCount = 0;
  logic [63:0] opE, opO;
  logic eV, oV, rEV, rOV, unitReserved, hold, done;
  logic [6:0] rE, rO;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  vector_popcount_parity_lzc dut (.core_clk, .reset, .go, .kField,
    .elementCount, .divSqrtBusy, .operandEven(opE), .operandEvenValid(eV),
    .operandOdd(opO), .operandOddValid(oV), .resultEven(rE),
    .resultEvenValid(rEV), .resultOdd(rO), .resultOddValid(rOV),
    .unitReserved, .scalarDivHold(hold), .done);
  steer_model feeder (.core_clk, .unitReserved, .slow, .opEven(opE),
    .evenValid(eV), .opOdd(opO), .oddValid(oV));
  task automatic check(string what, logic [6:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [6:0] model(logic [1:0] k, logic [63:0] v);
    logic [6:0] n;
    n = 7'h0;
    for (int i = 0; i < 64; i++) n += 7'(v[i]);
    if (k == vpop_pkg::K_PARITY) n = {6'h0, n[0]};
    if (k == vpop_pkg::K_LZC) n = vpop_pkg::ALL_ZERO_COUNT;
    for (int i = 0; i < 64; i++) begin
      if (k == vpop_pkg::K_LZC && v[i]) n = 7'(63 - i);
    end
    return n;
  endfunction : model
  task automatic run(logic [1:0] k, logic [7:0] n, logic s);
    int e, o;
    e = 0;
    o = 1;
    {kField, elementCount, slow, go} = {k, n, s, 1'b1};
    @(posedge core_clk) #1 go = 0;
    check("hold", {6'h0, hold}, 7'h1);
    while (!done) begin
      @(negedge core_clk);
      if (rEV) check("even", rE, model(k, feeder.vec[e]));
      if (rOV) check("odd", rO, model(k, feeder.vec[o]));
      e += rEV ? 2 : 0;
      o += rOV ? 2 : 0;
    end
    check("count", 7'((e + o - 1) / 2), n[6:0]);
    @(posedge core_clk) #1;
    check("free", {6'h0, hold}, 7'h0);
    $display("test k=%0d n=%0d over", k, n);
  endtask : run
  task automatic refuse;
    {divSqrtBusy, kField, elementCount, go} = {1'b1, 2'h1, 8'h2, 1'b1};
    @(posedge core_clk) #1 divSqrtBusy = 0;
    check("busy", {6'h0, unitReserved}, 7'h0);
    kField = 2'h0;
    @(posedge core_clk) #1 {kField, elementCount} = {2'h1, 8'h0};
    check("k0", {6'h0, unitReserved}, 7'h0);
    @(posedge core_clk) #1 go = 0;
    check("len0", {6'h0, unitReserved}, 7'h0);
    @(posedge core_clk) #1;
    $display("test refuse over");
  endtask : refuse
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    feeder.vec = '{64'h0, '1, 64'h1, 64'hf00};
    repeat (4) @(posedge core_clk);
    #1 reset = 0;
    refuse();
    run(2'h1, 8'h4, 1'b0);
    run(2'h2, 8'h3, 1'b1);
    run(2'h3, 8'h4, 1'b0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
